/* File: shared/rdport_pkg.sv */
package rdport_pkg;
  localparam int ID_W = 9;
  localparam int ADDR_W = 29;
  localparam int LEN_W = 8;
  localparam int DATA_W = 128;
  localparam int CHECK_W = 16;
  localparam int ROW_W = 14;
  localparam int COL_W = 6;
  localparam int BANK_W = 4;
  localparam int RESP_W = 2;
  localparam int CNT_W = 16;
  localparam int QOS_W = 4;
  // address field positions
  localparam int COL_LSB = 4;
  localparam int BANK_LSB_RBC = 10;
  localparam int ROW_LSB_RBC = 14;
  localparam int ROW_LSB_BRC = 10;
  localparam int BANK_LSB_BRC = 24;
  localparam int STACK_BIT = 28;
  localparam int GROUP_LSB = 2;
  localparam int GROUP_W = 2;
  // transfer encodings
  localparam logic [2:0] SIZE_32B = 3'h5;
  localparam logic [2:0] SIZE_64B = 3'h6;
  localparam logic [LEN_W-1:0] LEN_MAX_32B = 8'h01;
  localparam logic [LEN_W-1:0] LEN_MAX_64B = 8'h03;
  localparam logic [QOS_W-1:0] QOS_HIGH = 4'hf;
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
  // register map
  localparam int WB_ADR_W = 4;
  localparam logic [WB_ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [WB_ADR_W-1:0] REG_RD_COUNT = 4'h8;
  localparam logic [WB_ADR_W-1:0] REG_DBE_COUNT = 4'hc;
  localparam int CTRL_W = 3;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_8GB_BIT = 1;
  localparam int CTRL_ORDER_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CMD = 2'b01,
    S_DATA = 2'b10,
    S_ERR = 2'b11
  } port_state_t;
endpackage : rdport_pkg

/* File: src/port_regs.sv */
`timescale 1ns/100ps
module port_regs
  import rdport_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [WB_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_cal_ready,
  input wire logic i_busy,
  input wire logic [CNT_W-1:0] i_rd_count,
  input wire logic [CNT_W-1:0] i_dbe_count,
  output logic [CTRL_W-1:0] o_ctrl
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [CTRL_W-1:0] ctrl;
  } regs_t;

  localparam regs_t REGS_RST = '{ack: 1'b0, dat: 32'h0, ctrl: CTRL_RESET};

  regs_t q;
  regs_t n;
  logic [31:0] rd_mux;

  always_comb begin
    unique case (i_wb_adr)
      REG_CTRL: rd_mux = {29'h0, q.ctrl};
      REG_STATUS: rd_mux = {30'h0, i_busy, i_cal_ready};
      REG_RD_COUNT: rd_mux = {16'h0, i_rd_count};
      REG_DBE_COUNT: rd_mux = {16'h0, i_dbe_count};
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    n = q;
    if (i_ce) begin
      // ack lasts one cycle, then drops even if the master still holds stb
      n.ack = i_wb_cyc && i_wb_stb && !q.ack;
      if (i_wb_cyc && i_wb_stb && !q.ack) begin
        n.dat = rd_mux;
      end
      // write lands on the edge where the master samples ack
      if (i_wb_cyc && i_wb_stb && q.ack && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_CTRL) begin
        n.ctrl = i_wb_dat[CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= REGS_RST;
    end else begin
      q <= n;
    end
  end

  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.dat;
  assign o_ctrl = q.ctrl;
endmodule : port_regs

/* File: src/axi_read_port.sv */
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/100ps
module axi_read_port
  import rdport_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cal_done,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [WB_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [ID_W-1:0] i_arid,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [LEN_W-1:0] i_arlen,
  input wire logic [2:0] i_arsize,
  input wire logic [1:0] i_arburst,
  input wire logic [2:0] i_arprot,
  input wire logic [QOS_W-1:0] i_arqos,
  input wire logic i_aruser,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [ID_W-1:0] o_rid,
  output logic [DATA_W-1:0] o_rdata,
  output logic [CHECK_W-1:0] o_ruser_data,
  output logic o_ruser_err_dbe,
  output logic [RESP_W-1:0] o_rresp,
  output logic o_rlast,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_mem_cmd_valid,
  input wire logic i_mem_cmd_ready,
  output logic [BANK_W:0] o_mem_bank_index,
  output logic [GROUP_W-1:0] o_mem_group_index,
  output logic [ROW_W-1:0] o_mem_row_index,
  output logic [COL_W-1:0] o_mem_col_index,
  output logic o_mem_burst8,
  output logic o_mem_high_prio,
  output logic o_mem_auto_precharge,
  input wire logic i_mem_rd_valid,
  input wire logic [DATA_W-1:0] i_mem_rd_data,
  input wire logic [CHECK_W-1:0] i_mem_rd_check,
  input wire logic i_mem_rd_dbe,
  output logic o_mem_rd_ready
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    port_state_t st;
    logic cal_meta;
    logic cal_sync;
    logic arready;
    logic [ID_W-1:0] id;
    logic [LEN_W-1:0] beats_left;
    logic cmd_valid;
    logic [BANK_W:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic burst8;
    logic high_prio;
    logic auto_pre;
    logic mem_rd_ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [CHECK_W-1:0] rcheck;
    logic rdbe;
    logic [RESP_W-1:0] rresp;
    logic rlast;
    logic [CNT_W-1:0] rd_count;
    logic [CNT_W-1:0] dbe_count;
  } port_t;

  localparam port_t PORT_RST = '0;

  port_t q;
  port_t n;
  logic [CTRL_W-1:0] ctrl;
  logic ar_take;
  logic r_take;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the datapath and its checks
  // stack bit is masked on the small stack so a stray top bit cannot alias a bank
  function automatic logic [BANK_W:0] bank_of(input logic [ADDR_W-1:0] a, input logic order,
                                             input logic big);
    logic [BANK_W-1:0] b;
    b = order ? a[BANK_LSB_BRC +: BANK_W] : a[BANK_LSB_RBC +: BANK_W];
    return {big & a[STACK_BIT], b};
  endfunction : bank_of

  function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a, input logic order);
    return order ? a[ROW_LSB_BRC +: ROW_W] : a[ROW_LSB_RBC +: ROW_W];
  endfunction : row_of

  function automatic logic size_fits(input logic [2:0] size, input logic [LEN_W-1:0] len);
    return (size == SIZE_32B && len <= LEN_MAX_32B) || (size == SIZE_64B && len <= LEN_MAX_64B);
  endfunction : size_fits

  ////////////////////////////////////////////////////////////////////////////
  port_regs u_regs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_cal_ready(q.cal_sync),
    .i_busy(q.st != S_IDLE),
    .i_rd_count(q.rd_count),
    .i_dbe_count(q.dbe_count),
    .o_ctrl(ctrl)
  );

  assign ar_take = q.arready && i_arvalid;
  assign r_take = q.rvalid && i_rready;

  ////////////////////////////////////////////////////////////////////////////
  // burst type and protection are accepted but steer nothing: one burst only
  always_comb begin
    n = q;
    if (i_ce) begin
      n.cal_meta = i_cal_done;
      n.cal_sync = q.cal_meta;
      unique case (q.st)
        S_IDLE: begin
          // ready may rise with no request pending; one request in flight keeps order
          n.arready = q.cal_sync && ctrl[CTRL_ENABLE_BIT] && !ar_take;
          if (ar_take) begin
            n.id = i_arid;
            n.beats_left = i_arlen;
            n.bank = bank_of(i_araddr, ctrl[CTRL_ORDER_BIT], ctrl[CTRL_8GB_BIT]);
            n.row = row_of(i_araddr, ctrl[CTRL_ORDER_BIT]);
            n.col = i_araddr[COL_LSB +: COL_W];
            n.burst8 = i_arsize == SIZE_64B;
            n.high_prio = i_arqos == QOS_HIGH;
            n.auto_pre = i_aruser;
            if (size_fits(i_arsize, i_arlen)) begin
              n.st = S_CMD;
              n.cmd_valid = 1'b1;
            end else begin
              // unsupported shape: answer every beat with an error, no memory access
              n.st = S_ERR;
              n.rvalid = 1'b1;
              n.rdata = '0;
              n.rcheck = '0;
              n.rdbe = 1'b0;
              n.rresp = RESP_SLVERR;
              n.rlast = i_arlen == 8'h00;
            end
          end
        end
        S_CMD: begin
          if (i_mem_cmd_ready) begin
            n.cmd_valid = 1'b0;
            n.mem_rd_ready = 1'b1;
            n.st = S_DATA;
          end
        end
        S_DATA: begin
          // one beat held at a time: half rate, but no skid buffer needed
          if (q.mem_rd_ready && i_mem_rd_valid) begin
            n.mem_rd_ready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = i_mem_rd_data;
            n.rcheck = i_mem_rd_check;
            n.rdbe = i_mem_rd_dbe;
            n.rresp = RESP_OKAY;
            n.rlast = q.beats_left == 8'h00;
            if (i_mem_rd_dbe) begin
              n.dbe_count = q.dbe_count + 16'h1;
            end
          end
          // payload stays put while the master stalls
          if (r_take) begin
            n.rvalid = 1'b0;
            if (q.rlast) begin
              n.st = S_IDLE;
              n.rd_count = q.rd_count + 16'h1;
            end else begin
              n.beats_left = q.beats_left - 8'h1;
              n.mem_rd_ready = 1'b1;
            end
          end
        end
        S_ERR: begin
          if (r_take) begin
            if (q.rlast) begin
              n.rvalid = 1'b0;
              n.st = S_IDLE;
            end else begin
              n.beats_left = q.beats_left - 8'h1;
              n.rlast = q.beats_left == 8'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= PORT_RST;
    end else begin
      q <= n;
    end
  end

  assign o_arready = q.arready;
  assign o_rid = q.id;
  assign o_rdata = q.rdata;
  assign o_ruser_data = q.rcheck;
  assign o_ruser_err_dbe = q.rdbe;
  assign o_rresp = q.rresp;
  assign o_rlast = q.rlast;
  assign o_rvalid = q.rvalid;
  assign o_mem_cmd_valid = q.cmd_valid;
  assign o_mem_bank_index = q.bank;
  assign o_mem_group_index = q.bank[GROUP_LSB +: GROUP_W];
  assign o_mem_row_index = q.row;
  assign o_mem_col_index = q.col;
  assign o_mem_burst8 = q.burst8;
  assign o_mem_high_prio = q.high_prio;
  assign o_mem_auto_precharge = q.auto_pre;
  assign o_mem_rd_ready = q.mem_rd_ready;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers
  // beat count kept apart from the datapath counter so the last-beat check is independent
  logic [ID_W-1:0] chk_id;
  logic [LEN_W-1:0] chk_len;
  logic [LEN_W-1:0] chk_beats;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_id <= '0;
      chk_len <= '0;
      chk_beats <= '0;
    end else if (i_ce) begin
      if (ar_take) begin
        chk_id <= i_arid;
        chk_len <= i_arlen;
        chk_beats <= '0;
      end else if (r_take) begin
        chk_beats <= chk_beats + 8'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_ar_cal_gate: assert property ((i_ce && !q.cal_sync) |=> !o_arready)
    else $error("address ready rose before calibration");
  a_ar_one_take: assert property ((i_ce && ar_take) |=> !o_arready [*2])
    else $error("address ready stayed high after a taken request");
  a_r_hold: assert property ((o_rvalid && !i_rready) |=>
      (o_rvalid && $stable(o_rdata) && $stable(o_rid) && $stable(o_rlast)))
    else $error("read beat changed before handshake");
  a_rid_tag: assert property (o_rvalid |-> o_rid == chk_id)
    else $error("read ID differs from request ID");
  a_last_beat: assert property (o_rvalid |-> (o_rlast == (chk_beats == chk_len)))
    else $error("last flag on wrong beat");
  a_dbe_align: assert property (
      (i_ce && q.st == S_DATA && o_mem_rd_ready && i_mem_rd_valid)
      |=> (o_rvalid && o_ruser_err_dbe == $past(i_mem_rd_dbe)
      && o_ruser_data == $past(i_mem_rd_check)))
    else $error("error flag or check bits misaligned with valid");
  a_resp_okay: assert property ((o_rvalid && q.st == S_DATA) |-> o_rresp == RESP_OKAY)
    else $error("good read not marked okay");
  a_qos_map: assert property ($rose(o_mem_cmd_valid) |->
      o_mem_high_prio == ($past(i_arqos) == QOS_HIGH))
    else $error("priority does not follow qos");
  a_ap_map: assert property ($rose(o_mem_cmd_valid) |->
      o_mem_auto_precharge == $past(i_aruser))
    else $error("auto-precharge does not follow user bit");
  a_bank_decode: assert property ($rose(o_mem_cmd_valid) |->
      (o_mem_bank_index == bank_of($past(i_araddr), ctrl[CTRL_ORDER_BIT], ctrl[CTRL_8GB_BIT])
      && o_mem_row_index == row_of($past(i_araddr), ctrl[CTRL_ORDER_BIT])))
    else $error("bank or row decode wrong");
  a_in_order: assert property (o_arready |-> (!o_rvalid && !o_mem_cmd_valid))
    else $error("new request accepted while one is in flight");
  a_burst_size: assert property ($rose(o_mem_cmd_valid) |->
      o_mem_burst8 == ($past(i_arsize) == SIZE_64B))
    else $error("burst length does not follow transfer size");
  a_err_resp: assert property ((o_rvalid && q.st == S_ERR) |->
      (o_rresp == RESP_SLVERR && !o_ruser_err_dbe))
    else $error("refused read not marked as error");
  a_ar_refuse: assert property ((i_ce && !ctrl[CTRL_ENABLE_BIT]) |=> !o_arready)
    else $error("address ready high while port disabled");
  a_beat_gap: assert property (o_rvalid |-> !o_mem_rd_ready)
    else $error("memory beat taken while a read beat waits");

  c_read_64b: cover property (ar_take && i_arsize == SIZE_64B ##[1:60] (r_take && o_rlast));
  c_read_err: cover property (q.st == S_ERR && r_take && o_rlast);
  c_r_stall: cover property (o_rvalid && !i_rready ##1 r_take);
  c_high_prio: cover property (o_mem_cmd_valid && o_mem_high_prio && i_mem_cmd_ready);
  c_small_stack: cover property (o_mem_cmd_valid && !ctrl[CTRL_8GB_BIT] && ctrl[CTRL_ORDER_BIT]);
endmodule : axi_read_port

/* File: tb/mem_model.sv */
`timescale 1ns/100ps
module mem_model
  import rdport_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [ROW_W-1:0] i_row,
  input wire logic [COL_W-1:0] i_col,
  input wire logic [7:0] i_beats,
  input wire logic i_slow,
  input wire logic [7:0] i_dbe_at,
  input wire logic i_rd_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic [CHECK_W-1:0] o_rd_check,
  output logic o_rd_dbe
);
  logic [7:0] left_reg, idx_reg;
  logic [1:0] gap_reg;
  logic [ROW_W-1:0] row_reg;
  logic [COL_W-1:0] col_reg;
  logic [DATA_W-1:0] pat;
  //////////////////////////////////////////
  assign o_cmd_ready = (left_reg == 8'h0);
  assign o_rd_valid = (left_reg != 8'h0) && (gap_reg == 2'h0);
  assign pat = {100'h0, row_reg, col_reg, idx_reg};
  // idle bus inverts, so stale data never passes
  assign o_rd_data = o_rd_valid ? pat : ~pat;
  assign o_rd_check = o_rd_valid ? {8'hc3, idx_reg} : ~{8'hc3, idx_reg};
  assign o_rd_dbe = o_rd_valid ? (idx_reg == i_dbe_at) : 1'b1;
  // beat state moves only on a handshake and the gap counts down only while no beat is raised, so a raised beat stands
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left_reg <= 8'h0;
      idx_reg <= 8'h0;
      gap_reg <= 2'h0;
      row_reg <= '0;
      col_reg <= '0;
    end else if (i_cmd_valid && o_cmd_ready) begin
      left_reg <= i_beats;
      idx_reg <= 8'h0;
      gap_reg <= i_slow ? 2'h3 : 2'h0;
      row_reg <= i_row;
      col_reg <= i_col;
    end else if (o_rd_valid && i_rd_ready) begin
      left_reg <= left_reg - 8'h1;
      idx_reg <= idx_reg + 8'h1;
      gap_reg <= i_slow ? 2'h3 : 2'h0;
    end else if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end
  end
endmodule : mem_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import rdport_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cal_done = 1'b0, i_rready = 1'b1;
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, i_aruser = 1'b0, i_arvalid = 1'b0;
  logic [WB_ADR_W-1:0] i_wb_adr = '0;
  logic [31:0] i_wb_dat = '0, o_wb_dat, q, c0, d0;
  logic [ID_W-1:0] i_arid = '0, o_rid;
  logic [ADDR_W-1:0] i_araddr = '0;
  logic [LEN_W-1:0] i_arlen = '0;
  logic [2:0] i_arsize = '0;
  logic [QOS_W-1:0] i_arqos = '0;
  logic o_wb_ack, o_arready, o_ruser_err_dbe, o_rlast, o_rvalid, o_mem_cmd_valid;
  logic i_mem_cmd_ready, o_mem_burst8, o_mem_high_prio, o_mem_auto_precharge;
  logic i_mem_rd_valid, i_mem_rd_dbe, o_mem_rd_ready;
  logic [DATA_W-1:0] o_rdata, i_mem_rd_data;
  logic [CHECK_W-1:0] o_ruser_data, i_mem_rd_check;
  logic [RESP_W-1:0] o_rresp;
  logic [BANK_W:0] o_mem_bank_index;
  logic [GROUP_W-1:0] o_mem_group_index;
  logic [ROW_W-1:0] o_mem_row_index;
  logic [COL_W-1:0] o_mem_col_index;
  logic [7:0] beats = 8'h1, dbe_at = 8'hff;
  logic slow = 1'b0;
  int err_total = 0, n_checks = 0, ncmd = 0;
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_mem_cmd_valid && i_mem_cmd_ready) ncmd++;
  axi_read_port u_dut (.*, .i_ce(1'b1), .i_wb_sel(4'hf), .i_arburst(2'h1),
    .i_arprot(3'h0));
  mem_model u_mem (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(o_mem_cmd_valid),
    .o_cmd_ready(i_mem_cmd_ready), .i_row(o_mem_row_index), .i_col(o_mem_col_index),
    .i_beats(beats), .i_slow(slow), .i_dbe_at(dbe_at), .i_rd_ready(o_mem_rd_ready),
    .o_rd_valid(i_mem_rd_valid), .o_rd_data(i_mem_rd_data), .o_rd_check(i_mem_rd_check),
    .o_rd_dbe(i_mem_rd_dbe));
  ////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // flag a wait watches: 0 ack, 1 arready, 2 cmd valid, 3 rvalid
  function automatic logic flag_of(input int w);
    return w == 0 ? o_wb_ack : w == 1 ? o_arready : w == 2 ? o_mem_cmd_valid : o_rvalid;
  endfunction : flag_of
  // sampled right at the edge, before the design's updates land
  task automatic hold_for(input int w);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (flag_of(w) !== 1'b1 && k < 100);
    if (k >= 100) chk(1'b0, 1'b1, "wait timeout");
  endtask : hold_for
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
    hold_for(0);
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask : wb
  // cfg is {ordering, 8gb}
  task automatic rd(input logic [8:0] id, input logic [28:0] a, input logic [7:0] len,
    input logic [2:0] sz, input logic [3:0] qs, input logic u, input logic [1:0] cfg,
    input logic good, input logic stall);
    logic [3:0] bk;
    logic [13:0] rw;
    logic [DATA_W-1:0] hold;
    int b, n0;
    bk = cfg[1] ? a[27:24] : a[13:10];
    rw = cfg[1] ? a[23:10] : a[27:14];
    n0 = ncmd;
    beats <= len + 8'h1;
    i_rready <= !stall;
    @(posedge i_clk);
    {i_arid, i_araddr, i_arlen, i_arsize, i_arqos, i_aruser, i_arvalid} <=
      {id, a, len, sz, qs, u, 1'b1};
    hold_for(1);
    i_arvalid <= 1'b0;
    if (good) begin
      hold_for(2);
      chk(o_mem_bank_index, {cfg[0] & a[28], bk}, "bank");
      chk(o_mem_group_index, bk[3:2], "group");
      chk({o_mem_row_index, o_mem_col_index}, {rw, a[9:4]}, "row col");
      chk(o_mem_burst8, sz == SIZE_64B, "burst8");
      chk(o_mem_high_prio, qs == QOS_HIGH, "prio");
      chk(o_mem_auto_precharge, u, "precharge");
    end
    for (b = 0; b <= len; b++) begin
      if (stall && b == 0) begin
        hold_for(3);
        hold = o_rdata;
        repeat (2) @(posedge i_clk);
        chk({o_rvalid, o_rdata}, {1'b1, hold}, "held beat");
        i_rready <= 1'b1;
      end
      hold_for(3);
      chk(o_rid, id, "rid");
      chk(o_rresp, good ? RESP_OKAY : RESP_SLVERR, "resp");
      chk(o_rlast, b == len, "last");
      chk(o_rdata, good ? {rw, a[9:4], b[7:0]} : 28'h0, "data");
      chk(o_ruser_data, good ? {8'hc3, b[7:0]} : 16'h0, "check");
      chk(o_ruser_err_dbe, good && b == dbe_at, "dbe");
    end
    chk(ncmd - n0, good, "cmd count");
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  task automatic t_cal();
    repeat (8) begin
      @(posedge i_clk);
      chk(o_arready, 1'b0, "ready early");
    end
    i_cal_done <= 1'b1;
    hold_for(1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1, "ctrl reset");
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[0], 1'b1, "calibrated");
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("test cal done");
  endtask : t_cal
  task automatic t_modes();
    rd(9'h1a5, 29'h0abcd5c0, 8'h3, SIZE_64B, 4'hf, 1'b1, 2'b00, 1'b1, 1'b1);
    wb(1'b1, REG_CTRL, 32'h7);
    slow <= 1'b1;
    rd(9'h0ff, 29'h12345660, 8'h1, SIZE_32B, 4'h7, 1'b0, 2'b11, 1'b1, 1'b0);
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(o_arready, 1'b0, "port disabled");
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0, "ctrl readback");
    wb(1'b1, REG_CTRL, 32'h5);
    rd(9'h044, 29'h1123f400, 8'h1, SIZE_32B, 4'h0, 1'b1, 2'b10, 1'b1, 1'b0);
    wb(1'b1, REG_CTRL, 32'h1);
    slow <= 1'b0;
    rd(9'h102, 29'h00002020, 8'h0, SIZE_32B, 4'h0, 1'b0, 2'b00, 1'b1, 1'b0);
    $display("test modes done");
  endtask : t_modes
  task automatic t_same_id();
    wb(1'b0, REG_RD_COUNT, 32'h0);
    c0 = q;
    wb(1'b0, REG_DBE_COUNT, 32'h0);
    d0 = q;
    dbe_at <= 8'h2;
    rd(9'h033, 29'h00000400, 8'h3, SIZE_64B, 4'h0, 1'b0, 2'b00, 1'b1, 1'b0);
    rd(9'h033, 29'h0fffffc0, 8'h3, SIZE_64B, 4'h0, 1'b0, 2'b00, 1'b1, 1'b0);
    dbe_at <= 8'hff;
    wb(1'b0, REG_RD_COUNT, 32'h0);
    chk(q[15:0], c0[15:0] + 16'h2, "good reads");
    wb(1'b0, REG_DBE_COUNT, 32'h0);
    chk(q[15:0], d0[15:0] + 16'h2, "dbe beats");
    $display("test same id done");
  endtask : t_same_id
  task automatic t_bad();
    rd(9'h100, 29'h00001000, 8'h2, SIZE_32B, 4'h0, 1'b0, 2'b00, 1'b0, 1'b0);
    rd(9'h101, 29'h00000000, 8'h0, 3'h4, 4'h0, 1'b0, 2'b00, 1'b0, 1'b0);
    $display("test bad shape done");
  endtask : t_bad
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_cal();
    t_modes();
    t_same_id();
    t_bad();
    close_out();
  end
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule : testbench
